// ---- dtc_top.sv ----
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_top
    import dtc_pkg::*;
#(
    parameter bit VARIANT_12B = 1'b0
)
(
    // Clock and reset
    input  wire logic      i_clock,
    input  wire logic      i_resetn,
    // Register port
    input  wire dtc_req_t  i_req,
    output logic [15:0]    o_rdata,
    // Pins
    input  wire logic      i_load_strobe_n,
    input  wire logic      i_over_temp,
    // Converter side
    output dtc_bank_t      o_dac,
    output logic           o_amp_en,
    // Interrupt
    output logic           o_irq
);

    logic [1:0]  rst_sync_r;
    logic        rst_n;
    dtc_state_t  s_r;
    dtc_state_t  s_nxt;
    logic [1:0]  rsel;
    logic [3:0]  wr_ch;
    logic        is_serial;
    logic        ctrl_hit;
    logic        data_hit;
    logic        to_b;
    logic        ld_fall;
    logic        ot;
    logic [1:0]  grp_en;
    logic [1:0]  sel_b;
    logic        mon_en;
    logic        soft_pu;
    logic        b_drop;
    logic [2:0]  ev;

    // Reset release through two flops
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign rst_n = rst_sync_r[1];

    // Request decode
    assign rsel      = i_req.addr[`DTC_RSEL_HI:`DTC_RSEL_LO];
    assign wr_ch     = i_req.addr[3:0];
    assign is_serial = ~i_req.addr[`DTC_SPACE_BIT];
    assign to_b      = i_req.addr[`DTC_AB_BIT];
    assign ctrl_hit  = is_serial && rsel == `DTC_RSEL_CTRL && wr_ch == `DTC_CTRL_CHAN;
    assign data_hit  = is_serial && rsel == `DTC_RSEL_DATA;

    // Enables per variant
    assign grp_en = VARIANT_12B ?
                    {s_r.ctrl[`DTC_CR_TOG1_12B], s_r.ctrl[`DTC_CR_TOG0_12B]} :
                    {s_r.ctrl[`DTC_CR_TOG1_14B], s_r.ctrl[`DTC_CR_TOG0_14B]};
    assign mon_en = VARIANT_12B ? s_r.ctrl[`DTC_CR_THERM_12B] :
                                  s_r.ctrl[`DTC_CR_THERM_14B];

    // Falling edge of the synchronised load strobe; rate is the host's
    assign ld_fall = s_r.ld_prev & ~s_r.ld_sync[1];
    assign ot      = s_r.ot_sync[1];
    assign soft_pu = i_req.wr && i_req.addr == `DTC_ADDR_CMD &&
                     i_req.wdata[`DTC_CMD_SOFT_PU];
    assign b_drop  = i_req.wr && data_hit && to_b && !grp_en[wr_ch[3]];

    // One alternation tracker per group of eight
    for (genvar g = 0; g < 2; g++)
    begin : g_grp
        dtc_toggle_grp u_grp (
            .i_clock  (i_clock),
            .i_rst_n  (rst_n),
            .i_en     (grp_en[g]),
            .i_strobe (ld_fall),
            .o_sel_b  (sel_b[g])
        );
    end

    always_comb
    begin
        logic [15:0] rd_val;
        rd_val = 16'h0000;
        s_nxt  = s_r;
        ev     = 3'h0;

        s_nxt.ld_sync = {s_r.ld_sync[0], i_load_strobe_n};
        s_nxt.ld_prev = s_r.ld_sync[1];
        s_nxt.ot_sync = {s_r.ot_sync[0], i_over_temp};

        // Writes
        if (i_req.wr)
        begin
            if (ctrl_hit)
                s_nxt.ctrl = i_req.wdata;
            if (data_hit && !to_b)
                s_nxt.a[wr_ch] = i_req.wdata[13:0];
            if (data_hit && to_b && grp_en[wr_ch[3]])
                s_nxt.b[wr_ch] = i_req.wdata[13:0];
            if (i_req.addr == `DTC_ADDR_MASK)
                s_nxt.mask = i_req.wdata[2:0];
        end

        // Load strobe moves A or B into every DAC register
        if (ld_fall)
        begin
            for (int i = 0; i < 16; i++)
                s_nxt.dac[i] = sel_b[i / 8] ? s_r.b[i] : s_r.a[i];
        end

        // Thermal shutdown latch
        if (!mon_en)
            s_nxt.shutdown = 1'b0;
        else if (ot)
            s_nxt.shutdown = 1'b1;
        else if (soft_pu)
            s_nxt.shutdown = 1'b0;
        s_nxt.amp_en = ~s_nxt.shutdown;

        // Sticky events, set wins over write-one-to-clear
        ev[`DTC_EV_SHUTDOWN] = s_nxt.shutdown & ~s_r.shutdown;
        ev[`DTC_EV_LOAD]     = ld_fall;
        ev[`DTC_EV_BDROP]    = b_drop;
        s_nxt.status = s_r.status;
        if (i_req.wr && i_req.addr == `DTC_ADDR_STATUS)
            s_nxt.status = s_r.status & ~i_req.wdata[2:0];
        s_nxt.status = s_nxt.status | ev;
        s_nxt.irq    = |(s_nxt.status & s_nxt.mask);

        // Reads
        if (ctrl_hit)
            rd_val = s_r.ctrl;
        else if (data_hit)
            rd_val = {2'h0, to_b ? s_r.b[wr_ch] : s_r.a[wr_ch]};
        else if (i_req.addr == `DTC_ADDR_STATUS)
            rd_val = {13'h0000, s_r.status};
        else if (i_req.addr == `DTC_ADDR_MASK)
            rd_val = {13'h0000, s_r.mask};
        else if (i_req.addr == `DTC_ADDR_STATE)
            rd_val = {11'h000, s_r.amp_en, s_r.shutdown, ot, sel_b};
        s_nxt.rdata = i_req.rd ? rd_val : 16'h0000;
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r          <= '0;
            s_r.ld_sync  <= `DTC_SYNC_IDLE_RST;
            s_r.ld_prev  <= 1'b1;
            s_r.ot_sync  <= `DTC_SYNC_LOW_RST;
            s_r.ctrl     <= `DTC_CTRL_RST;
            s_r.amp_en   <= 1'b1;
            s_r.status   <= `DTC_STATUS_RST;
            s_r.mask     <= `DTC_MASK_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata  = s_r.rdata;
    assign o_dac    = s_r.dac;
    assign o_amp_en = s_r.amp_en;
    assign o_irq    = s_r.irq;

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    property p_ctrl_write;
        i_req.wr && ctrl_hit |=> s_r.ctrl == $past(i_req.wdata);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not stored");

    property p_grp_14b;
        !VARIANT_12B && ld_fall && !s_r.ctrl[`DTC_CR_TOG0_14B]
            |=> s_r.dac[0] == $past(s_r.a[0]);
    endproperty
    a_grp_14b: assert property (p_grp_14b)
        else $error("14-bit group off did not load A");

    property p_grp_12b;
        VARIANT_12B && ld_fall && !s_r.ctrl[`DTC_CR_TOG1_12B]
            |=> s_r.dac[15] == $past(s_r.a[15]);
    endproperty
    a_grp_12b: assert property (p_grp_12b)
        else $error("12-bit group off did not load A");

    property p_a_write;
        i_req.wr && data_hit && !to_b && !ld_fall
            |=> s_r.a[$past(wr_ch)] == $past(i_req.wdata[13:0]);
    endproperty
    a_a_write: assert property (p_a_write)
        else $error("A register write lost");

    property p_b_blocked;
        i_req.wr && data_hit && to_b && !grp_en[wr_ch[3]]
            |=> s_r.b[$past(wr_ch)] == $past(s_r.b[wr_ch]) && s_r.status[`DTC_EV_BDROP];
    endproperty
    a_b_blocked: assert property (p_b_blocked)
        else $error("B register written while toggle off");

    property p_toggle_b;
        ld_fall && grp_en[0] && sel_b[0] |=> s_r.dac[3] == $past(s_r.b[3]) && !sel_b[0];
    endproperty
    a_toggle_b: assert property (p_toggle_b)
        else $error("toggle did not select B");

    property p_first_a;
        ld_fall && grp_en[1] && !sel_b[1] && $stable(grp_en[1])
            |=> s_r.dac[9] == $past(s_r.a[9]) ##0 (sel_b[1] || !grp_en[1]);
    endproperty
    a_first_a: assert property (p_first_a)
        else $error("first strobe did not load A");

    property p_off_loads_a;
        ld_fall && !grp_en[0] |=> s_r.dac[7] == $past(s_r.a[7]);
    endproperty
    a_off_loads_a: assert property (p_off_loads_a)
        else $error("toggle off still selects B");

    property p_mon_off;
        !mon_en |=> !s_r.shutdown && o_amp_en;
    endproperty
    a_mon_off: assert property (p_mon_off)
        else $error("shutdown while monitor off");

    property p_shutdown;
        mon_en && ot |=> s_r.shutdown ##0 !o_amp_en;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("over-temperature did not power down");

    property p_soft_pu;
        s_r.shutdown && mon_en && !ot && soft_pu |=> !s_r.shutdown && o_amp_en;
    endproperty
    a_soft_pu: assert property (p_soft_pu)
        else $error("soft power-up did not release");

    property p_latched;
        s_r.shutdown && mon_en && !soft_pu |=> s_r.shutdown;
    endproperty
    a_latched: assert property (p_latched)
        else $error("shutdown released by itself");

    property p_restart_a;
        $changed(grp_en[1]) |-> !sel_b[1];
    endproperty
    a_restart_a: assert property (p_restart_a)
        else $error("alternation not restarted at A");

    property p_b_write;
        i_req.wr && data_hit && to_b && grp_en[wr_ch[3]]
            |=> s_r.b[$past(wr_ch)] == $past(i_req.wdata[13:0]);
    endproperty
    a_b_write: assert property (p_b_write)
        else $error("B register write lost while toggling");

    property p_grp1_off;
        ld_fall && !grp_en[1] |=> s_r.dac[12] == $past(s_r.a[12]);
    endproperty
    a_grp1_off: assert property (p_grp1_off)
        else $error("group without toggle did not load A");

    property p_shut_event;
        s_r.shutdown && !$past(s_r.shutdown) |-> s_r.status[`DTC_EV_SHUTDOWN];
    endproperty
    a_shut_event: assert property (p_shut_event)
        else $error("shutdown event not recorded");

    c_toggle_b: cover property (ld_fall && sel_b[0]);
    c_shutdown: cover property (mon_en && ot ##1 s_r.shutdown);
    c_b_drop:   cover property (b_drop);
    c_irq:      cover property (o_irq);
    c_soft_pu:  cover property (s_r.shutdown && soft_pu && !ot ##1 o_amp_en);

endmodule : dtc_top

// ---- dtc_defs.svh ----
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// Address layout of the register port
`define DTC_SPACE_BIT       7
`define DTC_AB_BIT          6
`define DTC_RSEL_HI         5
`define DTC_RSEL_LO         4
`define DTC_RSEL_CTRL       2'h0
`define DTC_RSEL_DATA       2'h3
`define DTC_CTRL_CHAN       4'hc

// Local registers
`define DTC_ADDR_STATUS     8'h80
`define DTC_ADDR_MASK       8'h81
`define DTC_ADDR_CMD        8'h82
`define DTC_ADDR_STATE      8'h83

// Control register bit positions
`define DTC_CR_TOG1_14B     3
`define DTC_CR_TOG0_14B     2
`define DTC_CR_TOG1_12B     1
`define DTC_CR_TOG0_12B     0
`define DTC_CR_THERM_14B    8
`define DTC_CR_THERM_12B    6

// Command register bit positions
`define DTC_CMD_SOFT_PU     0

// Status and mask bit positions
`define DTC_EV_W            3
`define DTC_EV_SHUTDOWN     0
`define DTC_EV_LOAD         1
`define DTC_EV_BDROP        2

// Reset values
`define DTC_CTRL_RST        16'h0000
`define DTC_MASK_RST        3'h0
`define DTC_STATUS_RST      3'h0
`define DTC_SYNC_IDLE_RST   2'h3
`define DTC_SYNC_LOW_RST    2'h0

`endif

// ---- dtc_pkg.sv ----
package dtc_pkg;

    typedef logic [13:0]       dtc_word_t;
    typedef logic [15:0][13:0] dtc_bank_t;

    // One register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } dtc_req_t;

    // State of the top module except the reset synchroniser
    typedef struct packed {
        logic [1:0]  ld_sync;
        logic        ld_prev;
        logic [1:0]  ot_sync;
        logic [15:0] ctrl;
        dtc_bank_t   a;
        dtc_bank_t   b;
        dtc_bank_t   dac;
        logic        shutdown;
        logic        amp_en;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic        irq;
        logic [15:0] rdata;
    } dtc_state_t;

    // Whole state of one toggle group
    typedef struct packed {
        logic phase;
    } dtc_grp_state_t;

endpackage : dtc_pkg

// ---- dtc_toggle_grp.sv ----
`timescale 1ns/1ps

module dtc_toggle_grp
    import dtc_pkg::*;
(
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    // Control
    input  wire logic i_en,
    input  wire logic i_strobe,
    // Source select
    output logic      o_sel_b
);

    dtc_grp_state_t s_r;
    dtc_grp_state_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (!i_en)
            s_nxt.phase = 1'b0;
        else if (i_strobe)
            s_nxt.phase = ~s_r.phase;
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // Phase is zero whenever the group was off, so a fresh enable starts on A
    assign o_sel_b = i_en & s_r.phase;

endmodule : dtc_toggle_grp

// ---- dtc_host_model.sv ----
`timescale 1ns/1ps

module dtc_host_model
(
    // Clock
    input  wire logic i_clock,
    // Requests from the bench
    input  wire logic i_go,
    input  wire logic i_hot,
    // Pins toward the device
    output logic      o_load_strobe_n,
    output logic      o_over_temp
);
    logic [2:0] low_cnt_r = 3'h0;

    // Strobe held low four cycles so the pin synchroniser cannot miss it
    always_ff @(posedge i_clock)
    begin
        if (i_go)
            low_cnt_r <= 3'h4;
        else if (low_cnt_r != 3'h0)
            low_cnt_r <= low_cnt_r - 3'h1;
    end

    assign o_load_strobe_n = (low_cnt_r == 3'h0);
    assign o_over_temp     = i_hot;
endmodule : dtc_host_model

// ---- tb_top.sv ----
`timescale 1ns/1ps

module tb_top
    import dtc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } dtc_row_t;

    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    dtc_req_t    req = '0;
    logic [15:0] rdata;
    logic        strobe_n;
    logic        over_temp;
    dtc_bank_t   dac;
    logic        amp_en;
    logic        irq;
    logic [15:0] rdata_12b;
    dtc_bank_t   dac_12b;
    logic        amp_en_12b;
    logic        irq_12b;
    logic        go = 1'b0;
    logic        hot = 1'b0;
    int          fail_count = 0;
    int          checks = 0;
    logic [15:0] rd_v;
    dtc_row_t    rows [8];

    always #20 clock = ~clock;

    dtc_top uut (
        .i_clock         (clock),
        .i_resetn        (resetn),
        .i_req           (req),
        .o_rdata         (rdata),
        .i_load_strobe_n (strobe_n),
        .i_over_temp     (over_temp),
        .o_dac           (dac),
        .o_amp_en        (amp_en),
        .o_irq           (irq)
    );

    // Second device with the 12-bit bit layout, sharing port and pins
    dtc_top #(.VARIANT_12B(1'b1)) uut_12b (
        .i_clock         (clock),
        .i_resetn        (resetn),
        .i_req           (req),
        .o_rdata         (rdata_12b),
        .i_load_strobe_n (strobe_n),
        .i_over_temp     (over_temp),
        .o_dac           (dac_12b),
        .o_amp_en        (amp_en_12b),
        .o_irq           (irq_12b)
    );

    dtc_host_model host (
        .i_clock         (clock),
        .i_go            (go),
        .i_hot           (hot),
        .o_load_strobe_n (strobe_n),
        .o_over_temp     (over_temp)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock) req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clock) req <= '0;
        #1 d = rdata;
    endtask : rd

    // One load strobe, then time for sync and DAC update
    task automatic strobe(input logic [13:0] e0, input logic [13:0] e8);
        @(posedge clock) go <= 1'b1;
        @(posedge clock) go <= 1'b0;
        repeat (10) @(posedge clock);
        #1;
        chk({2'h0, dac[0]}, {2'h0, e0});
        chk({2'h0, dac[8]}, {2'h0, e8});
    endtask : strobe

    task automatic summarize;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (5000) @(posedge clock);
        fail_count++;
        summarize();
    end

    initial
    begin
        rows[0] = '{8'h0c, 16'h0004, 16'h0004};
        rows[1] = '{8'h30, 16'h0111, 16'h0111};
        rows[2] = '{8'h38, 16'h0222, 16'h0222};
        rows[3] = '{8'h70, 16'h0333, 16'h0333};
        rows[4] = '{8'h78, 16'h0444, 16'h0000};
        rows[5] = '{8'h31, 16'hc005, 16'h0005};
        rows[6] = '{8'h81, 16'h0001, 16'h0001};
        rows[7] = '{8'h90, 16'h1234, 16'h0000};
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk({15'h0, amp_en}, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        chk({2'h0, dac[0]}, 16'h0000);
        $display("reset test done");
        // Host order: toggle enable, two A, two B (the second dropped), one more A, the mask and an unmapped address, then strobes
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rd_v);
            chk(rd_v, rows[i].exp);
        end
        $display("register table test done");
        strobe(14'h0111, 14'h0222);
        strobe(14'h0333, 14'h0222);
        strobe(14'h0111, 14'h0222);
        wr(8'h0c, 16'h0000);
        strobe(14'h0111, 14'h0222);
        strobe(14'h0111, 14'h0222);
        wr(8'h0c, 16'h0004);
        strobe(14'h0111, 14'h0222);
        $display("toggle test done");
        @(posedge clock) hot <= 1'b1;
        repeat (6) @(posedge clock);
        #1 chk({15'h0, amp_en}, 16'h0001);
        wr(8'h0c, 16'h0100);
        repeat (5) @(posedge clock);
        #1 chk({15'h0, amp_en}, 16'h0000);
        chk({15'h0, irq}, 16'h0001);
        rd(8'h83, rd_v);
        chk(rd_v, 16'h000c);
        chk(rdata_12b, 16'h0014);
        wr(8'h82, 16'h0001);
        repeat (3) @(posedge clock);
        #1 chk({15'h0, amp_en}, 16'h0000);
        @(posedge clock) hot <= 1'b0;
        repeat (6) @(posedge clock);
        #1 chk({15'h0, amp_en}, 16'h0000);
        wr(8'h82, 16'h0001);
        repeat (2) @(posedge clock);
        #1 chk({15'h0, amp_en}, 16'h0001);
        @(posedge clock) hot <= 1'b1;
        repeat (6) @(posedge clock);
        #1 chk({15'h0, amp_en}, 16'h0000);
        wr(8'h0c, 16'h0000);
        repeat (2) @(posedge clock);
        #1 chk({15'h0, amp_en}, 16'h0001);
        @(posedge clock) hot <= 1'b0;
        $display("thermal test done");
        rd(8'h80, rd_v);
        chk(rd_v, 16'h0007);
        wr(8'h80, 16'h0007);
        repeat (2) @(posedge clock);
        #1 chk({15'h0, irq}, 16'h0000);
        rd(8'h80, rd_v);
        chk(rd_v, 16'h0000);
        $display("interrupt test done");
        // Bits 0 and 6 mean group 0 toggle and monitor only on the 12-bit device
        wr(8'h0c, 16'h0041);
        wr(8'h70, 16'h0555);
        rd(8'h70, rd_v);
        chk(rd_v, 16'h0333);
        chk(rdata_12b, 16'h0555);
        strobe(14'h0111, 14'h0222);
        chk({2'h0, dac_12b[0]}, 16'h0111);
        strobe(14'h0111, 14'h0222);
        chk({2'h0, dac_12b[0]}, 16'h0555);
        chk({2'h0, dac_12b[8]}, 16'h0222);
        @(posedge clock) hot <= 1'b1;
        repeat (6) @(posedge clock);
        #1 chk({15'h0, amp_en_12b}, 16'h0000);
        chk({15'h0, amp_en}, 16'h0001);
        chk({15'h0, irq_12b}, 16'h0001);
        wr(8'h0c, 16'h0000);
        repeat (2) @(posedge clock);
        #1 chk({15'h0, amp_en_12b}, 16'h0001);
        @(posedge clock) hot <= 1'b0;
        $display("variant test done");
        summarize();
    end
endmodule : tb_top
